// file: rtl/acq_test_pkg.sv
// constants and types for the acquisition self-test sequencer
// assumes a 10 mhz clock and an apb register bus with 8-bit addresses
package acq_test_pkg;

    // clock and pass time
    localparam int unsigned CLK_FREQ_KHZ   = 10000;
    localparam int unsigned PASS_TIME_MS   = 2000;
    localparam int unsigned PASS_LIMIT_CYC = PASS_TIME_MS * CLK_FREQ_KHZ;
    localparam int unsigned SETTLE_CYC     = 2;

    // subtest sizes
    localparam int unsigned LATCH_STEPS  = 6;
    localparam int unsigned COMP_VALUES  = 64;
    localparam int unsigned QRAM_DEPTH   = 256;
    localparam int unsigned QRAM_VALUES  = 4;
    localparam int unsigned QRAM_ADDR_W  = 8;
    localparam int unsigned SEQ_IDX_W    = 10;
    localparam int unsigned TIMER_W      = 25;

    // latch step indices (zero based)
    localparam logic [9:0] STEP_TRIG_SET = 10'h001;
    localparam logic [9:0] STEP_RUN_CLK  = 10'h004;
    localparam logic [9:0] STEP_RUN_FST  = 10'h003;
    localparam logic [9:0] STEP_HALT_A   = 10'h000;
    localparam logic [9:0] STEP_HALT_B   = 10'h002;
    localparam logic [9:0] STEP_HALT_C   = 10'h005;

    // qualifier ram
    localparam logic [15:0] QRAM_BASE_ADDR = 16'h4000;
    localparam logic [3:0]  QLINE_FILL     = 4'hf;
    localparam logic [3:0]  QBASE_FILL     = 4'h0;

    // register offsets
    localparam logic [7:0] REG_CTRL    = 8'h00;
    localparam logic [7:0] REG_STATUS  = 8'h04;
    localparam logic [7:0] REG_LATEST  = 8'h08;
    localparam logic [7:0] REG_CUM     = 8'h0c;
    localparam logic [7:0] REG_FAILS   = 8'h10;
    localparam logic [7:0] REG_PASSES  = 8'h14;

    // control and status bits
    localparam int unsigned CTRL_START_BIT  = 0;
    localparam int unsigned CTRL_STOP_BIT   = 1;
    localparam int unsigned STAT_RUN_BIT    = 0;
    localparam int unsigned STAT_OVR_BIT    = 1;

    // error word field positions in latest and cumulative words
    localparam int unsigned FLD_LATCH_LSB = 0;
    localparam int unsigned FLD_COMP_LSB  = 8;
    localparam int unsigned FLD_QDATA_LSB = 16;
    localparam int unsigned FLD_QADDR_LSB = 24;

    // reset values
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    typedef enum logic [1:0] {
        S_IDLE,
        S_DRIVE,
        S_SETTLE,
        S_SAMPLE
    } seq_state_t;

    typedef enum logic [2:0] {
        P_LATCH,
        P_COMP,
        P_QDATA,
        P_QBASE,
        P_QLINE
    } phase_t;

endpackage : acq_test_pkg

// file: rtl/acquisition_self_test.sv
// acquisition self-test sequencer with apb register slave
// assumes external trigger/run latches, comparator latches and qualifier
// ram answer within the settle time after each strobe
//
// Overview of operation
// R1: five subtests cover trigger, run latch and context paths, each own code; the P_QBASE phase has no error field of its own
// R2: once started the test loops over all subtests until a stop arrives
// R3: one full pass of all subtests finishes within two seconds
// R4: failure counter totals all errors; latest words show only last pass
// R5: cumulative words gather every error since start
// R6: latch check runs six ordered steps, halt resets the latches
// R7: trigger reads low after reset, high after set, low after reset
// R8: run reads low, high after clock edge, low after reset
// R9: six-bit latch word, bit k-1 set when step k fails
// R10: comparator input latch enabled and loaded with 0 to 63
// R11: comparator lines 1-6 mismatches set bits 0-5 of eight-bit word
// R12: all 256 qualifier ram locations written 0..3 and read back
// R13: two-bit qualifier word, bit 0 line one, bit 1 line two
// R14: base location at 4000h, all address lines low, written zero first
// R15: raise one address line, write 0fh, read base expecting zero
// R16: nonzero base flags last raised address line in address word
// R17: subtest words cleared each pass, cumulative and counter persist
////////////////////////////////////////////////////////////////////////////
`timescale 1ns/100ps

module acquisition_self_test #(
    parameter int unsigned PASS_LIMIT_CYC = acq_test_pkg::PASS_LIMIT_CYC,
    parameter int unsigned SETTLE_CYC     = acq_test_pkg::SETTLE_CYC
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             halt_out,
    output logic             trig_set,
    input  wire logic        trig_level,
    output logic             run_clk_out,
    input  wire logic        run_level,
    output logic             comp_enable,
    output logic             comp_load,
    output logic      [5:0]  comp_data,
    input  wire logic [5:0]  comparator_out_line,
    output logic             qram_we,
    output logic      [3:0]  qram_wdata,
    output logic      [7:0]  qual_ram_addr_line,
    output logic      [15:0] mcu_addr,
    input  wire logic        qualifier_bit_one,
    input  wire logic        qualifier_bit_two
);

    if (SETTLE_CYC < 1 || SETTLE_CYC > 255) begin : g_chk_settle
        $error("SETTLE_CYC must lie in 1..255");
    end
    if (PASS_LIMIT_CYC < 2 || PASS_LIMIT_CYC >= (1 << 25)) begin : g_chk_lim
        $error("PASS_LIMIT_CYC must lie in 2..2**25-1");
    end

    ////////////////////////////////////////////////////////////////////////
    // last index of each phase
    function automatic logic [9:0] last_index(input acq_test_pkg::phase_t p);
        case (p)
            acq_test_pkg::P_LATCH: last_index = 10'(acq_test_pkg::LATCH_STEPS - 1);
            acq_test_pkg::P_COMP:  last_index = 10'(acq_test_pkg::COMP_VALUES - 1);
            acq_test_pkg::P_QDATA: last_index = 10'(acq_test_pkg::QRAM_DEPTH
                                           * acq_test_pkg::QRAM_VALUES - 1);
            acq_test_pkg::P_QLINE: last_index = 10'(acq_test_pkg::QRAM_ADDR_W - 1);
            default:               last_index = 10'h000;
        endcase
    endfunction : last_index

    ////////////////////////////////////////////////////////////////////////
    // state
    acq_test_pkg::seq_state_t state_r, state_nxt;
    acq_test_pkg::phase_t     phase_r, phase_nxt;
    logic [9:0]  idx_r, idx_nxt;
    logic        sub_r, sub_nxt;
    logic [7:0]  wait_r;
    logic [24:0] timer_r;
    logic        overrun_r;
    logic        stop_pend_r;
    logic        pass_wrap;
    logic [5:0]  latch_err_r;
    logic [7:0]  comp_err_r;
    logic [1:0]  qd_err_r;
    logic [7:0]  qa_err_r;
    logic [31:0] cum_r;
    logic [15:0] fail_cnt_r;
    logic [15:0] pass_cnt_r;
    logic [31:0] prdata_r;
    logic [31:0] last_r;

    ////////////////////////////////////////////////////////////////////////
    // apb decode
    wire        apb_wr      = psel & penable & pwrite;
    wire        start_pulse = apb_wr & (paddr == acq_test_pkg::REG_CTRL)
                            & pwdata[acq_test_pkg::CTRL_START_BIT];
    wire        stop_req    = apb_wr & (paddr == acq_test_pkg::REG_CTRL)
                            & pwdata[acq_test_pkg::CTRL_STOP_BIT];
    wire        addr_ok     = (paddr == acq_test_pkg::REG_CTRL)
                            | (paddr == acq_test_pkg::REG_STATUS)
                            | (paddr == acq_test_pkg::REG_LATEST)
                            | (paddr == acq_test_pkg::REG_CUM)
                            | (paddr == acq_test_pkg::REG_FAILS)
                            | (paddr == acq_test_pkg::REG_PASSES);
    wire        running     = state_r != acq_test_pkg::S_IDLE;
    wire [31:0] latest_word = {qa_err_r, 6'h00, qd_err_r, comp_err_r,
                               2'b00, latch_err_r};
    wire [31:0] status_word = {30'h0, overrun_r, running};
    wire [31:0] rd_mux =
        (paddr == acq_test_pkg::REG_CTRL)   ? {31'h0, running} :
        (paddr == acq_test_pkg::REG_STATUS) ? status_word :
        (paddr == acq_test_pkg::REG_LATEST) ? last_r :
        (paddr == acq_test_pkg::REG_CUM)    ? cum_r :
        (paddr == acq_test_pkg::REG_FAILS)  ? {16'h0, fail_cnt_r} :
        (paddr == acq_test_pkg::REG_PASSES) ? {16'h0, pass_cnt_r} :
                                              acq_test_pkg::RST_WORD;

    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~addr_ok;
    assign prdata  = prdata_r;

    ////////////////////////////////////////////////////////////////////////
    // result checks
    wire       sampling  = state_r == acq_test_pkg::S_SAMPLE;
    wire       in_latch  = phase_r == acq_test_pkg::P_LATCH;
    wire       in_comp   = phase_r == acq_test_pkg::P_COMP;
    wire       in_qdata  = phase_r == acq_test_pkg::P_QDATA;
    wire       in_qline  = phase_r == acq_test_pkg::P_QLINE;
    wire       lat_obs   = (idx_r < acq_test_pkg::STEP_RUN_FST)
                         ? trig_level : run_level;
    wire       lat_exp   = (idx_r == acq_test_pkg::STEP_TRIG_SET)
                         | (idx_r == acq_test_pkg::STEP_RUN_CLK); // [R7] [R8]
    wire [1:0] qbits     = {qualifier_bit_two, qualifier_bit_one}; // [R13]
    wire [5:0] comp_mism = comparator_out_line ^ idx_r[5:0]; // [R11]
    wire [1:0] qd_mism   = qbits ^ idx_r[1:0]; // [R12]
    wire       qa_bad    = |qbits; // [R15]
    wire [5:0] lat_hit   = (sampling & in_latch & (lat_obs != lat_exp))
                         ? (6'h01 << idx_r[2:0]) : 6'h00; // [R9]
    wire [7:0] comp_hit  = (sampling & in_comp)
                         ? {2'b00, comp_mism} : 8'h00; // [R11]
    wire [1:0] qd_hit    = (sampling & in_qdata) ? qd_mism : 2'b00; // [R13]
    wire [7:0] qa_hit    = (sampling & in_qline & sub_r & qa_bad)
                         ? (8'h01 << idx_r[2:0]) : 8'h00; // [R16]
    wire       fail_now  = (|lat_hit) | (|comp_hit) | (|qd_hit) | (|qa_hit);
    wire [31:0] hit_word = {qa_hit, 6'h00, qd_hit, comp_hit, 2'b00, lat_hit};
    wire       pass_start = start_pulse | pass_wrap;

    ////////////////////////////////////////////////////////////////////////
    // sequencer next state
    always_comb begin
        state_nxt = state_r;
        phase_nxt = phase_r;
        idx_nxt   = idx_r;
        sub_nxt   = sub_r;
        pass_wrap = 1'b0;
        case (state_r)
            acq_test_pkg::S_IDLE: begin
            end
            acq_test_pkg::S_DRIVE: begin
                state_nxt = acq_test_pkg::S_SETTLE;
            end
            acq_test_pkg::S_SETTLE: begin
                if (wait_r == 8'(SETTLE_CYC - 1)) begin
                    state_nxt = acq_test_pkg::S_SAMPLE;
                end
            end
            acq_test_pkg::S_SAMPLE: begin
                state_nxt = acq_test_pkg::S_DRIVE;
                if (stop_pend_r) begin
                    state_nxt = acq_test_pkg::S_IDLE; // [R2]
                end else if (in_qline & ~sub_r) begin
                    sub_nxt = 1'b1; // [R15]
                end else if (idx_r != last_index(phase_r)) begin
                    idx_nxt = idx_r + 10'h001;
                    sub_nxt = 1'b0;
                end else begin
                    idx_nxt = 10'h000;
                    sub_nxt = 1'b0;
                    case (phase_r)
                        acq_test_pkg::P_LATCH: phase_nxt = acq_test_pkg::P_COMP;
                        acq_test_pkg::P_COMP:  phase_nxt = acq_test_pkg::P_QDATA;
                        acq_test_pkg::P_QDATA: phase_nxt = acq_test_pkg::P_QBASE;
                        acq_test_pkg::P_QBASE: phase_nxt = acq_test_pkg::P_QLINE;
                        default: begin
                            phase_nxt = acq_test_pkg::P_LATCH; // [R2]
                            pass_wrap = 1'b1;
                        end
                    endcase
                end
            end
            default: state_nxt = acq_test_pkg::S_IDLE;
        endcase
        if (start_pulse) begin
            state_nxt = acq_test_pkg::S_DRIVE;
            phase_nxt = acq_test_pkg::P_LATCH;
            idx_nxt   = 10'h000;
            sub_nxt   = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r <= acq_test_pkg::S_IDLE;
            phase_r <= acq_test_pkg::P_LATCH;
            idx_r   <= 10'h000;
            sub_r   <= 1'b0;
            wait_r  <= 8'h00;
        end else begin
            state_r <= state_nxt;
            phase_r <= phase_nxt;
            idx_r   <= idx_nxt;
            sub_r   <= sub_nxt;
            wait_r  <= (state_r == acq_test_pkg::S_SETTLE)
                     ? wait_r + 8'h01 : 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // stimulus outputs
    wire       drive    = (state_r == acq_test_pkg::S_DRIVE) & ~start_pulse;
    wire [7:0] addr_nxt =
        in_qdata             ? idx_r[9:2] :
        (in_qline & ~sub_r)  ? (8'h01 << idx_r[2:0]) : 8'h00; // [R14] [R15]
    wire [3:0] wdata_nxt =
        in_qdata ? {2'b00, idx_r[1:0]} :
        in_qline ? acq_test_pkg::QLINE_FILL : acq_test_pkg::QBASE_FILL;
    wire       halt_step = (idx_r == acq_test_pkg::STEP_HALT_A)
                         | (idx_r == acq_test_pkg::STEP_HALT_B)
                         | (idx_r == acq_test_pkg::STEP_HALT_C);
    wire       we_nxt    = drive & (in_qdata
                         | (phase_r == acq_test_pkg::P_QBASE)
                         | (in_qline & ~sub_r)); // [R12] [R14] [R15]

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            halt_out           <= 1'b0;
            trig_set           <= 1'b0;
            run_clk_out        <= 1'b0;
            comp_enable        <= 1'b0;
            comp_load          <= 1'b0;
            comp_data          <= 6'h00;
            qram_we            <= 1'b0;
            qram_wdata         <= 4'h0;
            qual_ram_addr_line <= 8'h00;
        end else begin
            halt_out    <= drive & in_latch & halt_step; // [R6]
            trig_set    <= drive & in_latch
                         & (idx_r == acq_test_pkg::STEP_TRIG_SET); // [R7]
            run_clk_out <= drive & in_latch
                         & (idx_r == acq_test_pkg::STEP_RUN_CLK); // [R8]
            comp_enable <= running & in_comp; // [R10]
            comp_load   <= drive & in_comp; // [R10]
            comp_data   <= idx_r[5:0]; // [R10]
            qram_we     <= we_nxt;
            qram_wdata  <= wdata_nxt;
            qual_ram_addr_line <= addr_nxt;
        end
    end

    assign mcu_addr = acq_test_pkg::QRAM_BASE_ADDR
                    | {8'h00, qual_ram_addr_line}; // [R14]

    ////////////////////////////////////////////////////////////////////////
    // error words, counters, pass timer and bus read data
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            latch_err_r <= 6'h00;
            comp_err_r  <= 8'h00;
            qd_err_r    <= 2'b00;
            qa_err_r    <= 8'h00;
            cum_r       <= acq_test_pkg::RST_WORD;
            last_r      <= acq_test_pkg::RST_WORD;
            fail_cnt_r  <= 16'h0000;
            pass_cnt_r  <= 16'h0000;
            stop_pend_r <= 1'b0;
            timer_r     <= 25'h0;
            overrun_r   <= 1'b0;
            prdata_r    <= acq_test_pkg::RST_WORD;
        end else begin
            latch_err_r <= pass_start ? 6'h00 : latch_err_r | lat_hit; // [R17]
            comp_err_r  <= pass_start ? 8'h00 : comp_err_r | comp_hit; // [R17]
            qd_err_r    <= pass_start ? 2'b00 : qd_err_r | qd_hit; // [R17]
            qa_err_r    <= pass_start ? 8'h00 : qa_err_r | qa_hit; // [R17]
            cum_r       <= start_pulse ? acq_test_pkg::RST_WORD
                                       : cum_r | hit_word; // [R5]
            last_r      <= start_pulse ? acq_test_pkg::RST_WORD
                         : pass_wrap ? latest_word | hit_word
                         : last_r; // [R4]
            if (start_pulse) begin
                fail_cnt_r <= 16'h0000;
            end else if (fail_now && fail_cnt_r != 16'hffff) begin
                fail_cnt_r <= fail_cnt_r + 16'h0001; // [R4]
            end
            if (start_pulse) begin
                pass_cnt_r <= 16'h0000;
            end else if (pass_wrap) begin
                pass_cnt_r <= pass_cnt_r + 16'h0001;
            end
            stop_pend_r <= stop_req
                         | (stop_pend_r & running & ~start_pulse);
            timer_r     <= pass_start ? 25'h0 :
                           (running && timer_r != 25'(PASS_LIMIT_CYC))
                           ? timer_r + 25'h1 : timer_r;
            overrun_r   <= ~start_pulse & (overrun_r | (running
                         & (timer_r == 25'(PASS_LIMIT_CYC)))); // [R3]
            prdata_r    <= (psel & ~penable) ? rd_mux : prdata_r;
        end
    end

endmodule : acquisition_self_test

// file: sim/acq_partner.sv
// far-side model: trigger and run latches, comparator latches, qualifier ram
// assumes one-cycle strobes on clk; fault inputs come from the bench
`timescale 1ns/100ps

module acq_partner (
    input  wire logic       clk,
    input  wire logic       halt_out,
    input  wire logic       trig_set,
    input  wire logic       run_clk_out,
    input  wire logic       comp_enable,
    input  wire logic       comp_load,
    input  wire logic [5:0] comp_data,
    input  wire logic       qram_we,
    input  wire logic [3:0] qram_wdata,
    input  wire logic [7:0] qual_ram_addr_line,
    input  wire logic       trig_stuck,
    input  wire logic [5:0] comp_flip,
    input  wire logic [1:0] qual_flip,
    input  wire logic [7:0] addr_stuck,
    output logic            trig_level,
    output logic            run_level,
    output logic      [5:0] comparator_out_line,
    output logic            qualifier_bit_one,
    output logic            qualifier_bit_two
);
    logic [3:0] mem_r [256];
    logic       trig_r;
    logic       run_r;
    logic [5:0] comp_r;
    wire  [7:0] addr_eff = qual_ram_addr_line & ~addr_stuck;

    always_ff @(posedge clk) begin
        if (halt_out) begin
            trig_r <= 1'b0;
            run_r  <= 1'b0;
        end else begin
            if (trig_set) trig_r <= 1'b1;
            if (run_clk_out) run_r <= 1'b1;
        end
        if (comp_load && comp_enable) comp_r <= comp_data;
        if (qram_we) mem_r[addr_eff] <= qram_wdata;
    end

    assign trig_level          = trig_r | trig_stuck;
    assign run_level           = run_r;
    assign comparator_out_line = comp_r ^ comp_flip;
    // qual_flip holds the data bits stuck low
    assign qualifier_bit_one   = mem_r[addr_eff][0] & ~qual_flip[0];
    assign qualifier_bit_two   = mem_r[addr_eff][1] & ~qual_flip[1];
endmodule : acq_partner

// file: sim/acq_test_props.sv
// assertions on the self-test sequencer ports
// bound into acquisition_self_test; check period of four cycles assumed
`timescale 1ns/100ps

module acq_test_props #(
    parameter int unsigned PASS_LIMIT_CYC = 3000,
    parameter int unsigned SETTLE_CYC     = 2
) (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        halt_out,
    input wire logic        trig_set,
    input wire logic        run_clk_out,
    input wire logic        comp_enable,
    input wire logic        comp_load,
    input wire logic [5:0]  comp_data,
    input wire logic        qram_we,
    input wire logic [3:0]  qram_wdata,
    input wire logic [7:0]  qual_ram_addr_line,
    input wire logic [15:0] mcu_addr
);
    wire [9:0] qidx = {qual_ram_addr_line, qram_wdata[1:0]};
    wire       strobe = halt_out | trig_set | run_clk_out | comp_load
                      | qram_we;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_trig_after_halt: assert property (
        trig_set |-> $past(halt_out, 4)) else $error("set without reset");
    a_run_after_steps: assert property (
        run_clk_out |-> $past(halt_out, 8) && $past(trig_set, 12)
            && !$past(halt_out, 4)) else $error("run clock out of order");
    a_strobe_pulse: assert property (
        strobe |=> !strobe) else $error("strobe longer than one cycle");
    a_comp_enabled: assert property (
        comp_load |-> comp_enable) else $error("load while disabled");
    a_comp_count: assert property (
        comp_load && comp_data != 6'h00 |-> $past(comp_load, 4)
            && comp_data == $past(comp_data, 4) + 6'h01)
        else $error("comparator value skipped");
    a_comp_first: assert property (
        comp_load && comp_data == 6'h00 |-> $past(halt_out, 4)
            && $past(run_clk_out, 8)) else $error("comparator too early");
    a_qdata_step: assert property (
        qram_we && qram_wdata != 4'hf && qidx != 10'h000
            |-> $past(qram_we, 4) && qidx == $past(qidx, 4) + 10'h001)
        else $error("ram data sequence broken");
    a_qline_walk: assert property (
        qram_we && qram_wdata == 4'hf |-> $onehot(qual_ram_addr_line)
            && (qual_ram_addr_line == 8'h01
                ? $past(qram_we, 4) && $past(qual_ram_addr_line, 4) == 8'h00
                : qual_ram_addr_line
                  == 8'($past(qual_ram_addr_line, 8) << 1)))
        else $error("address line walk broken");
    a_base_addr: assert property (
        mcu_addr == {8'h40, qual_ram_addr_line}) else $error("bad cpu address");

    c_comp_last: cover property (comp_load && comp_data == 6'h3f);
    c_line_top: cover property (qram_we && qual_ram_addr_line == 8'h80);
    c_run_clock: cover property (run_clk_out);
endmodule : acq_test_props

bind acquisition_self_test acq_test_props #(
    .PASS_LIMIT_CYC(PASS_LIMIT_CYC),
    .SETTLE_CYC    (SETTLE_CYC)
) u_acq_test_props (
    .clk, .rst_n, .halt_out, .trig_set, .run_clk_out, .comp_enable,
    .comp_load, .comp_data, .qram_we, .qram_wdata, .qual_ram_addr_line,
    .mcu_addr
);

// file: sim/acquisition_self_test_tb.sv
// self-checking bench: apb master, far-side model with fault injection
// assumes the sequencer and far-side model files are compiled first
`timescale 1ns/100ps

module acquisition_self_test_tb;
    logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, rerr;
    logic [7:0]  paddr, qual_ram_addr_line, addr_stuck;
    logic [31:0] pwdata, prdata, rdata, exp_word, p1;
    logic        halt_out, trig_set, trig_level, run_clk_out, run_level;
    logic        comp_enable, comp_load, qram_we, trig_stuck;
    logic        qualifier_bit_one, qualifier_bit_two;
    logic [5:0]  comp_data, comparator_out_line, comp_flip;
    logic [3:0]  qram_wdata;
    logic [1:0]  qual_flip;
    logic [15:0] mcu_addr;
    int          n_errors = 0;
    int          checks_done = 0;
    int          i, k, comp_f, qual_f, per;

    acquisition_self_test #(.PASS_LIMIT_CYC(6000), .SETTLE_CYC(2))
    u_acquisition_self_test (.clk, .rst_n, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .halt_out, .trig_set,
        .trig_level, .run_clk_out, .run_level, .comp_enable, .comp_load,
        .comp_data, .comparator_out_line, .qram_we, .qram_wdata,
        .qual_ram_addr_line, .mcu_addr, .qualifier_bit_one,
        .qualifier_bit_two);

    acq_partner u_acq_partner (.clk, .halt_out, .trig_set, .run_clk_out,
        .comp_enable, .comp_load, .comp_data, .qram_we, .qram_wdata,
        .qual_ram_addr_line, .trig_stuck, .comp_flip, .qual_flip,
        .addr_stuck, .trig_level, .run_level, .comparator_out_line,
        .qualifier_bit_one, .qualifier_bit_two);

    always #50 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rdata = prdata;
        rerr  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                          input string what);
        apb(1'b0, a, 32'h0);
        check(what, rdata, exp);
    endtask : rd_chk

    task automatic wait_passes(input logic [31:0] n);
        for (int j = 0; j < 200; j++) begin
            apb(1'b0, acq_test_pkg::REG_PASSES, 32'h0);
            if (rdata >= n) break;
            repeat (100) @(posedge clk);
        end
    endtask : wait_passes

    task automatic end_sim;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_sim

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (60000) @(posedge clk);
        n_errors++;
        end_sim();
    end

    initial begin
        clk = 1'b0; rst_n = 1'b0; psel = 1'b0; penable = 1'b0;
        pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0; trig_stuck = 1'b0;
        comp_flip = 6'h00; qual_flip = 2'b00; addr_stuck = 8'h00;
        void'($urandom(32'he0c70d27));
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        for (i = 0; i < 6; i++) rd_chk(8'(i * 4), 32'h0, "reset word");
        apb(1'b0, 8'($urandom_range(6, 63) << 2), 32'h0);
        check("unmapped data", rdata, 32'h0);
        check("unmapped error", {31'h0, rerr}, 32'h1);
        apb(1'b1, acq_test_pkg::REG_CTRL, 32'h1);
        wait_passes(2);
        rd_chk(acq_test_pkg::REG_STATUS, 32'h1, "status");
        rd_chk(acq_test_pkg::REG_LATEST, 32'h0, "clean latest");
        rd_chk(acq_test_pkg::REG_FAILS, 32'h0, "clean fails");
        comp_f = $urandom_range(1, 63);
        qual_f = $urandom_range(1, 2);
        k = $urandom_range(0, 7);
        trig_stuck <= 1'b1;
        comp_flip  <= 6'(comp_f);
        qual_flip  <= 2'(qual_f);
        addr_stuck <= 8'(1 << k);
        exp_word = (32'hff << (24 + k)) | (qual_f << 16) | (comp_f << 8) | 5;
        per = 2 + 64 + 512 + 8 - k;
        apb(1'b1, acq_test_pkg::REG_CTRL, 32'h1);
        wait_passes(1);
        rd_chk(acq_test_pkg::REG_LATEST, exp_word, "latest");
        apb(1'b0, acq_test_pkg::REG_FAILS, 32'h0);
        check("fails", {31'h0, rdata >= per && rdata < 2 * per}, 32'h1);
        trig_stuck <= 1'b0;
        comp_flip  <= 6'h00;
        qual_flip  <= 2'b00;
        addr_stuck <= 8'h00;
        apb(1'b0, acq_test_pkg::REG_PASSES, 32'h0);
        wait_passes(rdata + 2);
        rd_chk(acq_test_pkg::REG_LATEST, 32'h0, "healed latest");
        rd_chk(acq_test_pkg::REG_CUM, exp_word, "cumulative");
        apb(1'b1, acq_test_pkg::REG_CTRL, 32'h2);
        repeat (6) @(posedge clk);
        rd_chk(acq_test_pkg::REG_STATUS, 32'h0, "stopped");
        apb(1'b0, acq_test_pkg::REG_PASSES, 32'h0);
        p1 = rdata;
        repeat (5000) @(posedge clk);
        rd_chk(acq_test_pkg::REG_PASSES, p1, "passes held");
        end_sim();
    end
endmodule : acquisition_self_test_tb
